// file: logic/host_cfg_pkg.sv
package host_cfg_pkg;

  // Clock and serial ROM timing.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int ROM_SK_HALF_NS  = 1000;
  localparam int ROM_SK_HALF_CYC = (ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets within a bank and the bank select location.
  localparam logic [3:0] OFS_WORD0    = 4'h0;
  localparam logic [3:0] OFS_WORD1    = 4'h2;
  localparam logic [3:0] OFS_WORD2    = 4'h4;
  localparam logic [3:0] OFS_BANK_SEL = 4'hE;

  // Bank numbers.
  localparam logic [5:0] BANK_BASE = 6'h00;
  localparam logic [5:0] BANK_MAC  = 6'h02;
  localparam logic [5:0] BANK_BUS  = 6'h03;

  // Field positions.
  localparam int SPEED_LSB     = 0;
  localparam int ROM_CS_BIT    = 0;
  localparam int ROM_SK_BIT    = 1;
  localparam int ROM_DO_BIT    = 2;
  localparam int ROM_DI_BIT    = 3;
  localparam int ROM_EN_BIT    = 4;
  localparam int BASE_LSB      = 5;
  localparam int CFG_SPEED_BIT = 1;

  // Reset values, and the slow bus speed set by the ROM configuration word.
  localparam logic [15:0] BASE_ADDR_RST = 16'h0300;
  localparam logic [1:0]  SPEED_RST     = 2'h0;
  localparam logic [1:0]  SPEED_SLOW    = 2'h3;
  localparam logic [5:0]  BANK_RST      = 6'h00;
  localparam logic [2:0]  PIN_BITS_RST  = 3'h0;
  localparam logic [15:0] MAC_RST       = 16'h0000;

  // Serial ROM word addresses and command framing.
  localparam logic [5:0] ROM_WORD_BASE   = 6'h00;
  localparam logic [5:0] ROM_WORD_MAC_LO = 6'h01;
  localparam logic [5:0] ROM_WORD_MAC_MI = 6'h02;
  localparam logic [5:0] ROM_WORD_MAC_HI = 6'h03;
  localparam logic [5:0] ROM_WORD_CFG    = 6'h06;
  localparam logic [2:0] ROM_READ_CMD    = 3'h6;
  localparam logic [4:0] ROM_CMD_BITS    = 5'h09;
  localparam logic [4:0] ROM_LAST_CLOCK  = 5'h19;

  // Loader states, Gray coded along idle, select, shift, gap, done; gap back to select changes two bits.
  typedef enum logic [2:0] {
    LD_IDLE   = 3'b000,
    LD_SELECT = 3'b001,
    LD_SHIFT  = 3'b011,
    LD_GAP    = 3'b010,
    LD_DONE   = 3'b110
  } loader_state_t;

  // Register port request from the host bus interface.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Serial ROM pins driven by the device.
  typedef struct packed {
    logic cs;
    logic sk;
    logic dout;
  } rom_pins_t;

  // One word fetched by the loader.
  typedef struct packed {
    logic        valid;
    logic [5:0]  addr;
    logic [15:0] data;
  } rom_word_t;

endpackage : host_cfg_pkg

// file: logic/rom_word_loader.sv
`timescale 1ns/1ns
module rom_word_loader #(
  parameter int SK_HALF = host_cfg_pkg::ROM_SK_HALF_CYC
) (
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    start_i,
  input  wire logic                    din_i,
  output host_cfg_pkg::rom_pins_t      pins_o,
  output host_cfg_pkg::rom_word_t      word_o,
  output logic                         done_o
);

  typedef struct packed {
    host_cfg_pkg::loader_state_t state;
    logic [15:0]                 tick;
    logic [4:0]                  clocks;
    logic [8:0]                  out_sr;
    logic [15:0]                 in_sr;
    logic [5:0]                  addr;
    host_cfg_pkg::rom_pins_t     pins;
    logic                        valid;
    logic                        done;
  } loader_t;

  loader_t st_reg;
  loader_t st_next;
  logic    half_tick;

  // Next word in the fetch order; the configuration word is the last one.
  function automatic logic [5:0] next_addr(input logic [5:0] a);
    case (a)
      host_cfg_pkg::ROM_WORD_BASE:   next_addr = host_cfg_pkg::ROM_WORD_MAC_LO;
      host_cfg_pkg::ROM_WORD_MAC_LO: next_addr = host_cfg_pkg::ROM_WORD_MAC_MI;
      host_cfg_pkg::ROM_WORD_MAC_MI: next_addr = host_cfg_pkg::ROM_WORD_MAC_HI;
      host_cfg_pkg::ROM_WORD_MAC_HI: next_addr = host_cfg_pkg::ROM_WORD_CFG;
      default:                       next_addr = host_cfg_pkg::ROM_WORD_BASE;
    endcase
  endfunction : next_addr

  // The half-period enable paces the serial clock well below the ROM's limit.
  assign half_tick = (st_reg.tick == 16'(SK_HALF - 1));

  // Word fetch sequencer: nine command bits out, one dummy, sixteen data bits in.
  always_comb begin
    st_next       = st_reg;
    st_next.valid = 1'b0;
    st_next.tick  = half_tick ? 16'h0000 : 16'(st_reg.tick + 16'h0001);
    case (st_reg.state)
      host_cfg_pkg::LD_IDLE: begin
        st_next.tick = 16'h0000;
        if (start_i) begin
          st_next.state   = host_cfg_pkg::LD_SELECT;
          st_next.addr    = host_cfg_pkg::ROM_WORD_BASE;
          st_next.pins.cs = 1'b1;
        end
      end
      host_cfg_pkg::LD_SELECT: begin
        if (half_tick) begin
          st_next.state     = host_cfg_pkg::LD_SHIFT;
          st_next.clocks    = 5'h00;
          st_next.out_sr    = {host_cfg_pkg::ROM_READ_CMD, st_reg.addr};
          st_next.pins.dout = host_cfg_pkg::ROM_READ_CMD[2];
        end
      end
      host_cfg_pkg::LD_SHIFT: begin
        if (half_tick) begin
          if (!st_reg.pins.sk) begin
            st_next.pins.sk = 1'b1;
          end else begin
            // Data is taken at the falling edge, after the ROM has driven it.
            st_next.pins.sk = 1'b0;
            st_next.out_sr  = {st_reg.out_sr[7:0], 1'b0};
            st_next.pins.dout = (st_reg.clocks < 5'(host_cfg_pkg::ROM_CMD_BITS - 5'h01))
                              ? st_reg.out_sr[7] : 1'b0;
            if (st_reg.clocks > host_cfg_pkg::ROM_CMD_BITS) begin
              st_next.in_sr = {st_reg.in_sr[14:0], din_i};
            end
            st_next.clocks = 5'(st_reg.clocks + 5'h01);
            if (st_reg.clocks == host_cfg_pkg::ROM_LAST_CLOCK) begin
              st_next.state   = host_cfg_pkg::LD_GAP;
              st_next.pins.cs = 1'b0;
              st_next.valid   = 1'b1;
              st_next.in_sr   = {st_reg.in_sr[14:0], din_i};
            end
          end
        end
      end
      host_cfg_pkg::LD_GAP: begin
        // Chip select stays low one half period so the ROM ends the read.
        if (half_tick) begin
          if (st_reg.addr == host_cfg_pkg::ROM_WORD_CFG) begin
            st_next.state = host_cfg_pkg::LD_DONE;
            st_next.done  = 1'b1;
          end else begin
            st_next.state   = host_cfg_pkg::LD_SELECT;
            st_next.addr    = next_addr(st_reg.addr);
            st_next.pins.cs = 1'b1;
          end
        end
      end
      host_cfg_pkg::LD_DONE: begin
        st_next.tick = 16'h0000;
      end
      default: begin
        st_next.state = host_cfg_pkg::LD_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '{state: host_cfg_pkg::LD_IDLE, tick: 16'h0000, clocks: 5'h00,
                  out_sr: 9'h000, in_sr: 16'h0000, addr: 6'h00,
                  pins: 3'h0, valid: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_o = st_reg.pins;
  assign word_o = '{valid: st_reg.valid, addr: st_reg.addr, data: st_reg.in_sr};
  assign done_o = st_reg.done;

endmodule : rom_word_loader

// file: logic/host_cfg_regs.sv
`timescale 1ns/1ns
module host_cfg_regs #(
  parameter int SK_HALF = host_cfg_pkg::ROM_SK_HALF_CYC
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  host_cfg_pkg::reg_req_t    req_i,
  input  wire logic                 rom_present_strap_i,
  input  wire logic                 rom_serial_in_pin_i,
  output logic [15:0]               rdata_o,
  output logic                      rd_valid_o,
  output logic [15:0]               base_addr_o,
  output logic [47:0]               station_addr_o,
  output logic [1:0]                bus_speed_select_o,
  output logic                      rom_serial_out_pin_o,
  output logic                      rom_serial_clock_pin_o,
  output logic                      rom_chip_select_pin_o,
  output logic                      load_busy_o
);

  typedef struct packed {
    logic [5:0]              bank_select_field;
    logic [15:0]             base_addr;
    logic [15:0]             mac_low;
    logic [15:0]             mac_mid;
    logic [15:0]             mac_high;
    logic [1:0]              bus_speed_select;
    logic                    software_rom_access_enable;
    logic [2:0]              rom_pin_bits;
    logic [15:0]             rdata;
    logic                    rd_valid;
    logic                    started;
    logic                    strap;
    logic                    load_start;
    logic                    load_busy;
    host_cfg_pkg::rom_pins_t pins;
  } regs_t;

  regs_t                   st_reg;
  regs_t                   st_next;
  logic                    strap_meta_reg;
  logic                    strap_sync_reg;
  logic                    din_meta_reg;
  logic                    din_sync_reg;
  host_cfg_pkg::rom_pins_t loader_pins;
  host_cfg_pkg::rom_word_t loader_word;
  logic                    loader_done;
  logic                    hit_mac;
  logic                    hit_bus;
  logic                    hit_base;

  // Pin synchronisers; left out of reset so the strap level is valid at release.
  always_ff @(posedge clock_i) begin
    strap_meta_reg <= rom_present_strap_i;
    strap_sync_reg <= strap_meta_reg;
    din_meta_reg   <= rom_serial_in_pin_i;
    din_sync_reg   <= din_meta_reg;
  end

  // Fetches base, MAC and configuration words once after a reset with the strap high.
  rom_word_loader #(
    .SK_HALF (SK_HALF)
  ) u_loader (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .start_i (st_reg.load_start),
    .din_i   (din_sync_reg),
    .pins_o  (loader_pins),
    .word_o  (loader_word),
    .done_o  (loader_done)
  );

  // Bank decode of the low offsets.
  assign hit_mac  = (st_reg.bank_select_field == host_cfg_pkg::BANK_MAC);
  assign hit_bus  = (st_reg.bank_select_field == host_cfg_pkg::BANK_BUS);
  assign hit_base = (st_reg.bank_select_field == host_cfg_pkg::BANK_BASE);

  // Register file, loader capture and pin steering.
  always_comb begin
    st_next            = st_reg;
    st_next.rd_valid   = 1'b0;
    st_next.load_start = 1'b0;

    // The strap is caught in the first cycle after reset release.
    if (!st_reg.started) begin
      st_next.started    = 1'b1;
      st_next.strap      = strap_sync_reg;
      st_next.load_start = strap_sync_reg;
      st_next.load_busy  = strap_sync_reg;
    end
    if (loader_done) begin
      st_next.load_busy = 1'b0;
    end

    // Software writes.
    if (req_i.wr) begin
      if (req_i.addr == host_cfg_pkg::OFS_BANK_SEL) begin
        st_next.bank_select_field = req_i.wdata[5:0];
      end else if (hit_mac) begin
        case (req_i.addr)
          host_cfg_pkg::OFS_WORD0: st_next.mac_low  = req_i.wdata;
          host_cfg_pkg::OFS_WORD1: st_next.mac_mid  = req_i.wdata;
          host_cfg_pkg::OFS_WORD2: st_next.mac_high = req_i.wdata;
          default: begin
          end
        endcase
      end else if (hit_bus) begin
        case (req_i.addr)
          host_cfg_pkg::OFS_WORD0: begin
            st_next.bus_speed_select = req_i.wdata[host_cfg_pkg::SPEED_LSB +: 2];
          end
          host_cfg_pkg::OFS_WORD1: begin
            st_next.software_rom_access_enable = req_i.wdata[host_cfg_pkg::ROM_EN_BIT];
            st_next.rom_pin_bits = req_i.wdata[host_cfg_pkg::ROM_DO_BIT:host_cfg_pkg::ROM_CS_BIT];
          end
          default: begin
          end
        endcase
      end else if (hit_base && req_i.addr == host_cfg_pkg::OFS_WORD0) begin
        st_next.base_addr = {req_i.wdata[15:host_cfg_pkg::BASE_LSB],
                             host_cfg_pkg::BASE_LSB'(0)};
      end
    end

    // Loaded words win over a software write in the same cycle.
    if (loader_word.valid) begin
      case (loader_word.addr)
        host_cfg_pkg::ROM_WORD_BASE: begin
          st_next.base_addr = {loader_word.data[15:host_cfg_pkg::BASE_LSB],
                               host_cfg_pkg::BASE_LSB'(0)};
        end
        host_cfg_pkg::ROM_WORD_MAC_LO: st_next.mac_low  = loader_word.data;
        host_cfg_pkg::ROM_WORD_MAC_MI: st_next.mac_mid  = loader_word.data;
        host_cfg_pkg::ROM_WORD_MAC_HI: st_next.mac_high = loader_word.data;
        host_cfg_pkg::ROM_WORD_CFG: begin
          st_next.bus_speed_select = loader_word.data[host_cfg_pkg::CFG_SPEED_BIT]
                                   ? host_cfg_pkg::SPEED_SLOW
                                   : host_cfg_pkg::SPEED_RST;
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; unmapped offsets read as zero.
    if (req_i.rd) begin
      st_next.rd_valid = 1'b1;
      st_next.rdata    = 16'h0000;
      if (req_i.addr == host_cfg_pkg::OFS_BANK_SEL) begin
        st_next.rdata = {10'h000, st_reg.bank_select_field};
      end else if (hit_mac) begin
        case (req_i.addr)
          host_cfg_pkg::OFS_WORD0: st_next.rdata = st_reg.mac_low;
          host_cfg_pkg::OFS_WORD1: st_next.rdata = st_reg.mac_mid;
          host_cfg_pkg::OFS_WORD2: st_next.rdata = st_reg.mac_high;
          default: st_next.rdata = 16'h0000;
        endcase
      end else if (hit_bus) begin
        case (req_i.addr)
          host_cfg_pkg::OFS_WORD0: st_next.rdata = {14'h0000, st_reg.bus_speed_select};
          host_cfg_pkg::OFS_WORD1: begin
            st_next.rdata = {11'h000, st_reg.software_rom_access_enable,
                             din_sync_reg, st_reg.rom_pin_bits};
          end
          default: st_next.rdata = 16'h0000;
        endcase
      end else if (hit_base && req_i.addr == host_cfg_pkg::OFS_WORD0) begin
        st_next.rdata = st_reg.base_addr;
      end
    end

    // Software owns the pins only while its access bit is set.
    if (st_reg.software_rom_access_enable) begin
      st_next.pins.dout = st_reg.rom_pin_bits[host_cfg_pkg::ROM_DO_BIT];
      st_next.pins.sk   = st_reg.rom_pin_bits[host_cfg_pkg::ROM_SK_BIT];
      st_next.pins.cs   = st_reg.rom_pin_bits[host_cfg_pkg::ROM_CS_BIT];
    end else begin
      st_next.pins = loader_pins;
    end
  end

  // State register; the MAC words clear to zero since software fills them without a ROM.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_reg <= '{bank_select_field:          host_cfg_pkg::BANK_RST,
                  base_addr:                  host_cfg_pkg::BASE_ADDR_RST,
                  mac_low:                    host_cfg_pkg::MAC_RST,
                  mac_mid:                    host_cfg_pkg::MAC_RST,
                  mac_high:                   host_cfg_pkg::MAC_RST,
                  bus_speed_select:           host_cfg_pkg::SPEED_RST,
                  software_rom_access_enable: 1'b0,
                  rom_pin_bits:               host_cfg_pkg::PIN_BITS_RST,
                  rdata:                      16'h0000,
                  rd_valid:                   1'b0,
                  started:                    1'b0,
                  strap:                      1'b0,
                  load_start:                 1'b0,
                  load_busy:                  1'b0,
                  pins:                       3'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o                = st_reg.rdata;
  assign rd_valid_o             = st_reg.rd_valid;
  assign base_addr_o            = st_reg.base_addr;
  assign station_addr_o         = {st_reg.mac_high, st_reg.mac_mid, st_reg.mac_low};
  assign bus_speed_select_o     = st_reg.bus_speed_select;
  assign rom_serial_out_pin_o   = st_reg.pins.dout;
  assign rom_serial_clock_pin_o = st_reg.pins.sk;
  assign rom_chip_select_pin_o  = st_reg.pins.cs;
  assign load_busy_o            = st_reg.load_busy;

endmodule : host_cfg_regs

// file: tb/serial_rom_model.sv
`timescale 1ns/1ns
module serial_rom_model (
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic di_i,
  output logic      do_o
);
  logic [15:0] mem [64];
  logic [8:0]  cmd;
  logic [15:0] word;
  int          cnt;

  // A deselected part floats its output, so it is shown as a level that flips at each chip select change.
  initial do_o = 1'b0;
  always @(cs_i) begin
    cnt = 0;
    do_o = ~do_o;
  end

  // Start, opcode and address enter on rising clocks; a dummy zero stands through rise ten.
  // Data then leaves MSB first from rise eleven, matching the loader's dummy clock.
  always @(posedge sk_i) begin
    if (cs_i) begin
      cnt++;
      if (cnt <= 9) cmd = {cmd[7:0], di_i};
      if (cnt == 9) word = mem[cmd[5:0]];
      if (cnt == 9 || cnt == 10) do_o = 1'b0;
      else if (cnt >= 11 && cnt <= 26 && cmd[8:6] == 3'h6) do_o = word[26 - cnt];
      else if (cnt > 9) do_o = ~do_o;
    end
  end
endmodule : serial_rom_model

// file: tb/host_cfg_regs_asserts.sv
`timescale 1ns/1ns
module host_cfg_checker (
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input host_cfg_pkg::reg_req_t req_i,
  input wire logic              rom_present_strap_i,
  input wire logic              rom_serial_in_pin_i,
  input wire logic [15:0]       rdata_o,
  input wire logic              rd_valid_o,
  input wire logic [15:0]       base_addr_o,
  input wire logic [47:0]       station_addr_o,
  input wire logic [1:0]        bus_speed_select_o,
  input wire logic              rom_serial_out_pin_o,
  input wire logic              rom_serial_clock_pin_o,
  input wire logic              rom_chip_select_pin_o,
  input wire logic              load_busy_o
);
  logic [5:0] bank_reg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Shadow of the bank select, so offsets can be decoded per bank.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bank_reg <= 6'h00;
    end else if (req_i.wr && req_i.addr == 4'hE) begin
      bank_reg <= req_i.wdata[5:0];
    end
  end

  // Decoded register hits; writes racing the loader are left out since the loader wins.
  wire logic [2:0] pins = {rom_serial_out_pin_o, rom_serial_clock_pin_o, rom_chip_select_pin_o};
  wire logic mac_w0 = bank_reg == 6'h02 && req_i.addr == 4'h0;
  wire logic mac_w2 = bank_reg == 6'h02 && req_i.addr == 4'h2;
  wire logic mac_w4 = bank_reg == 6'h02 && req_i.addr == 4'h4;
  wire logic bus_w0 = bank_reg == 6'h03 && req_i.addr == 4'h0;
  wire logic bus_w2 = bank_reg == 6'h03 && req_i.addr == 4'h2;
  wire logic sw_wr  = req_i.wr && bus_w2 && !load_busy_o;

  property p_mac_low_rd;
    req_i.rd && mac_w0 |=> rd_valid_o && rdata_o == $past(station_addr_o[15:0]);
  endproperty
  a_mac_low_rd: assert property (p_mac_low_rd) else $error("mac low read wrong");
  property p_mac_mid_rd;
    req_i.rd && mac_w2 |=> rdata_o == $past(station_addr_o[31:16]);
  endproperty
  a_mac_mid_rd: assert property (p_mac_mid_rd) else $error("mac mid read wrong");
  property p_mac_high_wr;
    req_i.wr && mac_w4 && !load_busy_o |=> station_addr_o[47:32] == $past(req_i.wdata);
  endproperty
  a_mac_high_wr: assert property (p_mac_high_wr) else $error("mac high write lost");
  property p_speed_rd;
    req_i.rd && bus_w0 |=> rdata_o == {14'h0000, $past(bus_speed_select_o)};
  endproperty
  a_speed_rd: assert property (p_speed_rd) else $error("speed read wrong");
  property p_speed_wr;
    req_i.wr && bus_w0 && !load_busy_o |=> bus_speed_select_o == $past(req_i.wdata[1:0]);
  endproperty
  a_speed_wr: assert property (p_speed_wr) else $error("speed write lost");
  property p_bank_rd;
    req_i.rd && req_i.addr == 4'hE |=> rdata_o == {10'h000, $past(bank_reg)};
  endproperty
  a_bank_rd: assert property (p_bank_rd) else $error("bank select read wrong");
  property p_no_load;
    $rose(rst_n_i) && !rom_present_strap_i |-> base_addr_o == 16'h0300
      && bus_speed_select_o == 2'h0 ##1 !load_busy_o [*4];
  endproperty
  a_no_load: assert property (p_no_load) else $error("strapless defaults wrong");
  property p_load_start;
    $rose(rst_n_i) && rom_present_strap_i |-> ##[1:4] load_busy_o;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start");
  property p_sw_pins;
    sw_wr && req_i.wdata[4] |=> ##1 pins == $past(req_i.wdata[2:0], 2);
  endproperty
  a_sw_pins: assert property (p_sw_pins) else $error("pins not software driven");
  property p_sw_off;
    sw_wr && !req_i.wdata[4] ##1 !load_busy_o |=> pins == 3'h0;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("pins follow bits while off");
  property p_din_rd;
    req_i.rd && bus_w2 && $stable(rom_serial_in_pin_i)
      && rom_serial_in_pin_i == $past(rom_serial_in_pin_i, 2)
      |=> rdata_o[3] == $past(rom_serial_in_pin_i) && rdata_o[15:5] == 11'h000;
  endproperty
  a_din_rd: assert property (p_din_rd) else $error("data-in bit wrong");

  c_load_done: cover property ($fell(load_busy_o));
  c_sw_pins: cover property (pins == 3'h7);
  c_bank_rd: cover property (req_i.rd && req_i.addr == 4'hE);
endmodule : host_cfg_checker

bind host_cfg_regs host_cfg_checker u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
  .rom_present_strap_i(rom_present_strap_i), .rom_serial_in_pin_i(rom_serial_in_pin_i),
  .rdata_o(rdata_o), .rd_valid_o(rd_valid_o), .base_addr_o(base_addr_o),
  .station_addr_o(station_addr_o), .bus_speed_select_o(bus_speed_select_o),
  .rom_serial_out_pin_o(rom_serial_out_pin_o), .rom_serial_clock_pin_o(rom_serial_clock_pin_o),
  .rom_chip_select_pin_o(rom_chip_select_pin_o), .load_busy_o(load_busy_o)
);

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [5:0]  bank;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rexp;
  } row_t;
  localparam int         SK_HALF = 4;
  localparam logic [8:0] RD_W3   = 9'h183;
  logic                   clock_i = 1'b0;
  logic                   rst_n_i = 1'b0;
  host_cfg_pkg::reg_req_t req     = '0;
  logic                   strap   = 1'b0;
  logic                   ovr_en  = 1'b1;
  logic                   ovr_val = 1'b0;
  logic                   rom_dout;
  logic [15:0]            rdata;
  logic                   rd_valid;
  logic [15:0]            base;
  logic [47:0]            station;
  logic [1:0]             speed;
  wire logic [2:0]        pins;
  logic                   busy;
  logic [15:0]            d;
  logic [15:0]            got;
  int                     failures   = 0;
  int                     num_checks = 0;
  row_t                   rows [11];
  // The bench may pin the data-in line to a known level in place of the part.
  wire logic              din_pin = ovr_en ? ovr_val : rom_dout;

  // Bench clock, 100 ns period.
  always #50 clock_i = ~clock_i;

  host_cfg_regs #(.SK_HALF(SK_HALF)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req), .rom_present_strap_i(strap),
    .rom_serial_in_pin_i(din_pin), .rdata_o(rdata), .rd_valid_o(rd_valid),
    .base_addr_o(base), .station_addr_o(station), .bus_speed_select_o(speed),
    .rom_serial_out_pin_o(pins[2]), .rom_serial_clock_pin_o(pins[1]),
    .rom_chip_select_pin_o(pins[0]), .load_busy_o(busy)
  );
  serial_rom_model u_rom (.cs_i(pins[0]), .sk_i(pins[1]), .di_i(pins[2]), .do_o(rom_dout));

  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] seen);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Inputs move 10 ns after an edge, so no input changes on the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #10;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    tick(1);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    tick(1);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    tick(1);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    // The answer stands for the single cycle after the read edge, so it is taken now.
    chk("rd_valid", 48'(1'b1), 48'(rd_valid));
    v = rdata;
  endtask : rd

  task automatic bank(input logic [5:0] b);
    wr(4'hE, {10'h000, b});
  endtask : bank

  // Software owns the pins here, so every edge of the serial timing is paced by these writes.
  task automatic sw(input logic dv, input logic sk, input logic cs);
    wr(4'h2, {11'h000, 1'b1, 1'b0, dv, sk, cs});
  endtask : sw

  // The strap settles through its synchronizer before reset is asserted.
  task automatic reset_dut(input logic s);
    strap = s;
    tick(2);
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
  endtask : reset_dut

  task automatic wait_load();
    for (int n = 0; n < 3000 && busy === 1'b1; n++) tick(1);
    chk("load_end", 48'(1'b0), 48'(busy));
  endtask : wait_load

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Main sequence: strapless reset, table of accesses, pin control, then two ROM loads.
  initial begin
    rows = '{'{6'h02, 4'h0, 16'hABCD, 16'hABCD}, '{6'h02, 4'h2, 16'h1357, 16'h1357},
             '{6'h02, 4'h4, 16'hFFFF, 16'hFFFF}, '{6'h03, 4'h0, 16'h0001, 16'h0001},
             '{6'h03, 4'h0, 16'h0002, 16'h0002}, '{6'h03, 4'h0, 16'hFFFF, 16'h0003},
             '{6'h03, 4'h0, 16'h0000, 16'h0000}, '{6'h00, 4'h0, 16'hFFFF, 16'hFFE0},
             '{6'h01, 4'h0, 16'hFFFF, 16'h0000}, '{6'h02, 4'h6, 16'hFFFF, 16'h0000},
             '{6'h03, 4'h2, 16'hFFEF, 16'h0007}};
    u_rom.mem[0] = 16'h1234;
    u_rom.mem[1] = 16'h89AB;
    u_rom.mem[2] = 16'h4567;
    u_rom.mem[3] = 16'h0123;
    u_rom.mem[6] = 16'h0002;
    tick(2);
    rst_n_i = 1'b1;
    chk("base_rst", 48'(16'h0300), 48'(base));
    chk("speed_rst", 48'(2'h0), 48'(speed));
    chk("pins_rst", 48'(3'h0), 48'(pins));
    rd(4'hE, d);
    chk("bank_rst", 48'(16'h0000), 48'(d));
    bank(6'h03);
    rd(4'h2, d);
    chk("rom_ctl_rst", 48'(16'h0000), 48'(d));
    for (int i = 0; i < 11; i++) begin
      bank(rows[i].bank);
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk("row_rdata", 48'(rows[i].rexp), 48'(d));
    end
    chk("station", 48'hFFFF_1357_ABCD, station);
    chk("busy_strapless", 48'(1'b0), 48'(busy));
    chk("pins_sw_off", 48'(3'h0), 48'(pins));
    for (int v = 0; v < 8; v++) begin
      sw(v[2], v[1], v[0]);
      tick(1);
      chk("pins_sw", 48'(v[2:0]), 48'(pins));
    end
    rd(4'hE, d);
    chk("bank_any", 48'(16'h0003), 48'(d));
    ovr_val = 1'b1;
    tick(4);
    rd(4'h2, d);
    chk("din_high", 48'(16'h001F), 48'(d));
    ovr_en = 1'b0;
    sw(1'b0, 1'b0, 1'b0);
    sw(1'b0, 1'b0, 1'b1);
    for (int i = 8; i >= 0; i--) begin
      sw(RD_W3[i], 1'b0, 1'b1);
      sw(RD_W3[i], 1'b1, 1'b1);
    end
    // One dummy clock precedes the data word, as in the loader's framing.
    sw(1'b0, 1'b0, 1'b1);
    sw(1'b0, 1'b1, 1'b1);
    for (int i = 15; i >= 0; i--) begin
      sw(1'b0, 1'b0, 1'b1);
      sw(1'b0, 1'b1, 1'b1);
      tick(3);
      rd(4'h2, d);
      got[i] = d[3];
    end
    sw(1'b0, 1'b0, 1'b0);
    chk("sw_rom_read", 48'(16'h0123), 48'(got));
    reset_dut(1'b1);
    tick(4);
    chk("load_busy", 48'(1'b1), 48'(busy));
    wait_load();
    chk("base_load", 48'(16'h1220), 48'(base));
    chk("mac_load", 48'h0123_4567_89AB, station);
    chk("speed_load", 48'(2'h3), 48'(speed));
    bank(6'h02);
    rd(4'h0, d);
    chk("mac_low_rd", 48'(16'h89AB), 48'(d));
    bank(6'h03);
    wr(4'h0, 16'h0001);
    tick(1);
    chk("speed_after_load", 48'(2'h1), 48'(speed));
    u_rom.mem[6] = 16'hFFFD;
    reset_dut(1'b1);
    tick(4);
    wait_load();
    chk("speed_fast", 48'(2'h0), 48'(speed));
    test_done();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs.
  initial begin
    #(100 * 20000);
    failures++;
    test_done();
  end
endmodule : tb
